// [include/srf_defs.svh]
// Constants for the service request and special function decoder
`ifndef SRF_DEFS_SVH
`define SRF_DEFS_SVH

// Status byte field positions (bit 1 of the byte is index 0)
`define SRF_BIT_DATA_READY  0
`define SRF_BIT_CODE_ERROR  1
`define SRF_BIT_INSTR_ERROR 2
`define SRF_BIT_RQS         6
// Condition weights in the enable suffix
`define SRF_W_DATA_READY    3'h1
`define SRF_W_CODE_ERROR    3'h2
`define SRF_W_INSTR_ERROR   3'h4
`define SRF_MASK_RESET      3'h2
// Special function codes
`define SRF_PFX_DIRECT      7'h00
`define SRF_PFX_USER_LAST   7'h27
`define SRF_PFX_SERV_FIRST  7'h28
`define SRF_PFX_SERV_LAST   7'h63
`define SRF_PFX_SRQ_ENABLE  7'h16
`define SRF_PFX_RESOLUTION  7'h10
`define SRF_PFX_VIEW_LAST   7'h08
`define SRF_SFX_FULL_RES    7'h01
// Code flash time on the display
`define SRF_FLASH_NS        500
`define SRF_CLK_NS          5
`define SRF_FLASH_CYC       (`SRF_FLASH_NS / `SRF_CLK_NS)

`endif

// [include/srf_pkg.sv]
// Types for the service request and special function decoder
package srf_pkg;

	typedef enum logic [2:0] {
		SRF_MODE_AUTO    = 3'h1,
		SRF_MODE_USER    = 3'h2,
		SRF_MODE_SERVICE = 3'h4
	} srf_mode_t;

	typedef enum logic [3:0] {
		SRF_DISP_MEAS    = 4'h1,
		SRF_DISP_FLASH   = 4'h2,
		SRF_DISP_REQ     = 4'h4,
		SRF_DISP_ACTUAL  = 4'h8
	} srf_disp_t;

	typedef enum logic [1:0] {
		SRF_CLASS_DIRECT  = 2'h0,
		SRF_CLASS_USER    = 2'h1,
		SRF_CLASS_SERVICE = 2'h2,
		SRF_CLASS_BAD     = 2'h3
	} srf_class_t;

endpackage

// [rtl/srf_setting_mem.sv]
// Settings store for special function prefixes 1 to 8
`timescale 1ns/1ps

module srf_setting_mem (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// Write side
	input  wire logic       wr_en,
	input  wire logic [2:0] wr_addr,
	input  wire logic [6:0] wr_data,
	// Read side
	input  wire logic [2:0] rd_addr,
	output logic      [6:0] rd_data
);
	logic [6:0] mem_r [8];

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < 8; i++) begin
				mem_r[i] <= 7'h00;
			end
			rd_data <= 7'h00;
		end else begin
			if (wr_en) begin
				mem_r[wr_addr] <= wr_data;
			end
			rd_data <= mem_r[rd_addr];
		end
	end
endmodule

// [rtl/srf_service_request.sv]
// Status byte, service request and special function decoder
//
// Overview of operation
// RQ1 - Status byte: data ready bit1, code error bit2, instrument error bit3, RQS bit7.
// RQ2 - Enabled condition sets its status bit and the RQS flag.
// RQ3 - Enabled condition also drives the bus service request line true.
// RQ4 - Service request enable code flashes briefly, then measurement display returns.
// RQ5 - Address display shows whether a service request is pending.
// RQ6 - Codes arrive as prefix, decimal point and suffix, parsed as such.
// RQ7 - Prefix 0 selects direct control; errors and safeguards suppressed.
// RQ8 - Prefixes 1 to 39 are user functions; error reporting stays on.
// RQ9 - Prefixes 40 to 99 are service functions; most safeguards dropped.
// RQ10 - Automatic operation command leaves direct control or service function.
// RQ11 - First shift plus notch tune press shows requested settings 1 to 8.
// RQ12 - Second press shows actual settings of functions in automatic mode.
// RQ13 - Any key except local or shift clears the special displays.
// RQ14 - Power up with full resolution 16.1; 16.0 rounds low ratios.
// RQ15 - Enable mask is weight sum; code error always enabled.
// RQ16 - Status and request hold until poll, bus clear or controller clear.
// RQ17 - Bus clear or controller clear also disables the enable mask.
// RQ18 - Automatic operation leaves pending request and status unchanged.
// RQ19 - Service request line drops together with the RQS flag.
`timescale 1ns/1ps
`include "srf_defs.svh"

module srf_service_request (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rstn,
	// Special function code, one cycle strobe
	input  wire logic                 code_valid,
	input  wire logic [6:0]           code_prefix,
	input  wire logic [6:0]           code_suffix,
	input  wire logic                 code_has_point,
	// Bus commands
	input  wire logic                 auto_op_cmd,
	input  wire logic                 bus_clear,
	input  wire logic                 ctrl_clear,
	input  wire logic                 serial_poll,
	// Condition events
	input  wire logic                 ev_data_ready,
	input  wire logic                 ev_instr_error,
	// Front panel keys
	input  wire logic                 key_shift_notch,
	input  wire logic                 key_other,
	input  wire logic                 key_addr_disp,
	// Actual automatic settings for read back
	input  wire logic [6:0]           actual_setting,
	// Status and bus line
	output logic      [7:0]           status_byte,
	output logic                      srq_line,
	// Mode and display
	output srf_pkg::srf_mode_t        func_mode,
	output logic                      safeguards_off,
	output logic                      errors_suppressed,
	output srf_pkg::srf_disp_t        disp_state,
	output logic      [13:0]          disp_code,
	output logic      [6:0]           disp_setting,
	output logic                      disp_srq_pending,
	output logic                      full_resolution
);
	import srf_pkg::*;

	// ===================================================
	// Code classification
	function automatic srf_class_t classify(input logic [6:0] pfx);
		if (pfx == `SRF_PFX_DIRECT) begin
			return SRF_CLASS_DIRECT;
		end else if (pfx <= `SRF_PFX_USER_LAST) begin
			return SRF_CLASS_USER;
		end else if (pfx <= `SRF_PFX_SERV_LAST) begin
			return SRF_CLASS_SERVICE;
		end
		return SRF_CLASS_BAD;
	endfunction

	// ===================================================
	// State
	typedef struct packed {
		logic [2:0]  stat;
		logic        rqs;
		logic [2:0]  mask;
		srf_mode_t   mode;
		srf_disp_t   disp;
		logic [13:0] code;
		logic [7:0]  flash_cnt;
		logic [2:0]  view_idx;
		logic        full_res;
		logic        addr_disp;
	} srf_state_t;

	srf_state_t st_r;
	srf_state_t st_nxt;

	srf_class_t code_class;
	logic       code_err;
	logic       code_ok;
	logic [2:0] cond;
	logic       mem_wr;
	logic [6:0] mem_rd;

	srf_setting_mem u_mem (
		.clk     (clk),
		.rstn    (rstn),
		.wr_en   (mem_wr),
		.wr_addr (code_prefix[2:0] - 3'h1),
		.wr_data (code_suffix),
		.rd_addr (st_r.view_idx),
		.rd_data (mem_rd)
	);

	// ===================================================
	// Next state
	always_comb begin
		st_nxt     = st_r;
		code_class = classify(code_prefix);
		// Malformed codes are code errors
		code_err   = code_valid && (!code_has_point || code_class == SRF_CLASS_BAD); // [RQ6]
		code_ok    = code_valid && !code_err;
		mem_wr     = code_ok && code_prefix != 7'h00 && code_prefix <= `SRF_PFX_VIEW_LAST;
		cond       = {ev_instr_error, code_err, ev_data_ready} & st_r.mask; // [RQ15]

		// Clear by poll, bus clear or controller clear; auto op has no effect here
		if (serial_poll || bus_clear || ctrl_clear) begin // [RQ16] [RQ18]
			st_nxt.stat = 3'h0;
			st_nxt.rqs  = 1'b0; // [RQ19]
		end
		if (bus_clear || ctrl_clear) begin
			st_nxt.mask = `SRF_MASK_RESET; // [RQ17]
		end
		// Set wins over clear
		if (cond != 3'h0) begin
			st_nxt.stat = st_nxt.stat | cond; // [RQ2]
			st_nxt.rqs  = 1'b1; // [RQ3]
		end

		if (code_ok) begin
			unique case (code_class)
				SRF_CLASS_DIRECT:  st_nxt.mode = SRF_MODE_SERVICE; // [RQ7]
				SRF_CLASS_SERVICE: st_nxt.mode = SRF_MODE_SERVICE; // [RQ9]
				default:           st_nxt.mode = SRF_MODE_USER; // [RQ8]
			endcase
			if (code_prefix == `SRF_PFX_SRQ_ENABLE && !(bus_clear || ctrl_clear)) begin
				st_nxt.mask = code_suffix[2:0] | `SRF_W_CODE_ERROR; // [RQ15]
			end
			if (code_prefix == `SRF_PFX_RESOLUTION) begin
				st_nxt.full_res = (code_suffix == `SRF_SFX_FULL_RES); // [RQ14]
			end
			if (code_prefix == `SRF_PFX_SRQ_ENABLE) begin
				st_nxt.disp      = SRF_DISP_FLASH; // [RQ4]
				st_nxt.code      = {code_prefix, code_suffix};
				st_nxt.flash_cnt = 8'(`SRF_FLASH_CYC);
			end
		end
		if (auto_op_cmd) begin
			st_nxt.mode = SRF_MODE_AUTO; // [RQ10]
		end

		unique case (st_r.disp)
			SRF_DISP_FLASH: begin
				if (!(code_ok && code_prefix == `SRF_PFX_SRQ_ENABLE)) begin
					if (st_r.flash_cnt == 8'h01) begin
						st_nxt.disp = SRF_DISP_MEAS; // [RQ4]
					end
					st_nxt.flash_cnt = st_r.flash_cnt - 8'h01;
				end
			end
			SRF_DISP_MEAS: begin
				if (key_shift_notch) begin
					st_nxt.disp     = SRF_DISP_REQ; // [RQ11]
					st_nxt.view_idx = 3'h0;
				end
			end
			SRF_DISP_REQ: begin
				st_nxt.view_idx = st_r.view_idx + 3'h1;
				if (key_other) begin
					st_nxt.disp = SRF_DISP_MEAS; // [RQ13]
				end else if (key_shift_notch) begin
					st_nxt.disp = SRF_DISP_ACTUAL; // [RQ12]
				end
			end
			SRF_DISP_ACTUAL: begin
				if (key_other) begin
					st_nxt.disp = SRF_DISP_MEAS; // [RQ13]
				end
			end
			default: st_nxt.disp = SRF_DISP_MEAS;
		endcase

		if (key_addr_disp) begin
			st_nxt.addr_disp = 1'b1; // [RQ5]
		end else if (key_other) begin
			st_nxt.addr_disp = 1'b0;
		end
	end

	// ===================================================
	// Registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= '{stat: 3'h0, rqs: 1'b0, mask: `SRF_MASK_RESET, mode: SRF_MODE_AUTO,
			          disp: SRF_DISP_MEAS, code: 14'h0000, flash_cnt: 8'h00,
			          view_idx: 3'h0, full_res: 1'b1, addr_disp: 1'b0}; // [RQ14]
			status_byte       <= 8'h00;
			srq_line          <= 1'b0;
			func_mode         <= SRF_MODE_AUTO;
			safeguards_off    <= 1'b0;
			errors_suppressed <= 1'b0;
			disp_state        <= SRF_DISP_MEAS;
			disp_code         <= 14'h0000;
			disp_setting      <= 7'h00;
			disp_srq_pending  <= 1'b0;
			full_resolution   <= 1'b1;
		end else begin
			st_r              <= st_nxt;
			status_byte       <= {1'b0, st_nxt.rqs, 3'h0, st_nxt.stat}; // [RQ1]
			srq_line          <= st_nxt.rqs; // [RQ3] [RQ19]
			func_mode         <= st_nxt.mode;
			safeguards_off    <= st_nxt.mode == SRF_MODE_SERVICE; // [RQ7] [RQ9]
			errors_suppressed <= st_nxt.mode == SRF_MODE_SERVICE &&
			                     code_ok && code_class == SRF_CLASS_DIRECT ? 1'b1 :
			                     st_nxt.mode == SRF_MODE_SERVICE ? errors_suppressed : 1'b0;
			disp_state        <= st_nxt.disp;
			disp_code         <= st_nxt.code;
			disp_setting      <= st_nxt.disp == SRF_DISP_ACTUAL ? actual_setting : mem_rd; // [RQ12]
			disp_srq_pending  <= st_nxt.addr_disp && st_nxt.rqs; // [RQ5]
			full_resolution   <= st_nxt.full_res;
		end
	end
endmodule

// [verif/srf_ctrl_model.sv]
// Bus controller model: sends codes and bus commands
`timescale 1ns/1ps

module srf_ctrl_model (
	// Clock
	input  wire logic clk,
	// Code and commands
	output logic       code_valid,
	output logic [6:0] code_prefix,
	output logic [6:0] code_suffix,
	output logic       code_has_point,
	output logic       auto_op_cmd,
	output logic       bus_clear,
	output logic       ctrl_clear,
	output logic       serial_poll
);
	// ====================
	// Drivers
	logic [3:0] cmd_r = 4'h0;
	assign {auto_op_cmd, bus_clear, ctrl_clear, serial_poll} = cmd_r;
	initial begin
		code_valid = 1'b0;
		code_prefix = 7'h00;
		code_suffix = 7'h00;
		code_has_point = 1'b0;
	end
	// Prefix, point and suffix as one code; idle prefix and suffix inverted, point held
	task automatic send(input logic [6:0] p, input logic [6:0] s, input logic pt);
		@(posedge clk);
		code_valid <= 1'b1;
		code_prefix <= p;
		code_suffix <= s;
		code_has_point <= pt;
		@(posedge clk);
		code_valid <= 1'b0;
		code_prefix <= ~p;
		code_suffix <= ~s;
		#1;
	endtask
	// One cycle: auto op, bus clear, ctrl clear, poll
	task automatic cmd(input logic [3:0] v);
		@(posedge clk);
		cmd_r <= v;
		@(posedge clk);
		cmd_r <= 4'h0;
		#1;
	endtask
endmodule

// [verif/srf_service_request_asserts.sv]
// Port checks for the service request decoder
`timescale 1ns/1ps

module srf_service_request_asserts
	import srf_pkg::*;
(
	input wire logic       clk,
	input wire logic       rstn,
	input wire logic       code_valid,
	input wire logic [6:0] code_prefix,
	input wire logic       code_has_point,
	input wire logic       auto_op_cmd,
	input wire logic       bus_clear,
	input wire logic       ctrl_clear,
	input wire logic       serial_poll,
	input wire logic       ev_data_ready,
	input wire logic       ev_instr_error,
	input wire logic [7:0] status_byte,
	input wire logic       srq_line,
	input wire srf_mode_t  func_mode,
	input wire logic       safeguards_off,
	input wire srf_disp_t  disp_state
);
	// ====================
	// Assertions
	wire clr = serial_poll | bus_clear | ctrl_clear;
	wire evt = code_valid | ev_data_ready | ev_instr_error;
	wire ok = code_valid & code_has_point & !auto_op_cmd;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	AST_SRQ_TIE: assert property (srq_line == status_byte[6])
		else $error("srq line differs from flag");
	AST_CODE_ERR: assert property (code_valid && !code_has_point |=>
		status_byte[1] && status_byte[6]) else $error("code error not flagged");
	AST_HOLD: assert property (status_byte[6] && !clr |=> status_byte[6])
		else $error("request dropped");
	AST_POLL_CLR: assert property (clr && !evt |=> status_byte == 8'h00)
		else $error("status not cleared");
	AST_AUTO_KEEP: assert property (auto_op_cmd && !clr && !evt |=> $stable(status_byte))
		else $error("auto op changed status");
	AST_SERVICE: assert property (ok && code_prefix inside {[7'h28:7'h63]} |=>
		safeguards_off && func_mode == SRF_MODE_SERVICE) else $error("service mode");
	AST_AUTO: assert property (auto_op_cmd && !code_valid |=>
		func_mode == SRF_MODE_AUTO && !safeguards_off) else $error("auto mode");
	AST_FLASH: assert property (ok && code_prefix == 7'h16 |=>
		(disp_state == SRF_DISP_FLASH) [*8]) else $error("flash too short");
	cover property (srq_line && serial_poll);
	cover property (disp_state == SRF_DISP_ACTUAL);
	cover property (func_mode == SRF_MODE_SERVICE);
endmodule

bind srf_service_request srf_service_request_asserts i_chk (
	.clk            (clk),
	.rstn           (rstn),
	.code_valid     (code_valid),
	.code_prefix    (code_prefix),
	.code_has_point (code_has_point),
	.auto_op_cmd    (auto_op_cmd),
	.bus_clear      (bus_clear),
	.ctrl_clear     (ctrl_clear),
	.serial_poll    (serial_poll),
	.ev_data_ready  (ev_data_ready),
	.ev_instr_error (ev_instr_error),
	.status_byte    (status_byte),
	.srq_line       (srq_line),
	.func_mode      (func_mode),
	.safeguards_off (safeguards_off),
	.disp_state     (disp_state)
);

// [verif/srf_service_request_bench.sv]
// Self-checking bench for the service request decoder
`timescale 1ns/1ps

module srf_service_request_bench;
	import srf_pkg::*;
	// ====================
	// Signals
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [4:0] pv = 5'h0;
	wire key_addr_disp, key_other, key_shift_notch, ev_instr_error, ev_data_ready;
	logic [6:0] actual_setting = 7'h00;
	logic code_valid, code_has_point, auto_op_cmd, bus_clear, ctrl_clear, serial_poll;
	logic [6:0] code_prefix, code_suffix, disp_setting, s1;
	logic [7:0] status_byte, exp_sb;
	logic srq_line, safeguards_off, errors_suppressed, disp_srq_pending, full_resolution;
	srf_mode_t func_mode;
	srf_disp_t disp_state;
	logic [13:0] disp_code;
	logic [31:0] lfsr = 32'h480e4670;
	logic [6:0] pfx [5] = '{7'h00, 7'h01, 7'h27, 7'h28, 7'h63};
	logic svc;
	int miscompares = 0;
	int checks = 0;
	int mask;
	assign {key_addr_disp, key_other, key_shift_notch, ev_instr_error, ev_data_ready} = pv;
	srf_service_request i_dut (
		.clk               (clk),
		.rstn              (rstn),
		.code_valid        (code_valid),
		.code_prefix       (code_prefix),
		.code_suffix       (code_suffix),
		.code_has_point    (code_has_point),
		.auto_op_cmd       (auto_op_cmd),
		.bus_clear         (bus_clear),
		.ctrl_clear        (ctrl_clear),
		.serial_poll       (serial_poll),
		.ev_data_ready     (ev_data_ready),
		.ev_instr_error    (ev_instr_error),
		.key_shift_notch   (key_shift_notch),
		.key_other         (key_other),
		.key_addr_disp     (key_addr_disp),
		.actual_setting    (actual_setting),
		.status_byte       (status_byte),
		.srq_line          (srq_line),
		.func_mode         (func_mode),
		.safeguards_off    (safeguards_off),
		.errors_suppressed (errors_suppressed),
		.disp_state        (disp_state),
		.disp_code         (disp_code),
		.disp_setting      (disp_setting),
		.disp_srq_pending  (disp_srq_pending),
		.full_resolution   (full_resolution)
	);
	srf_ctrl_model i_ctrl (
		.clk            (clk),
		.code_valid     (code_valid),
		.code_prefix    (code_prefix),
		.code_suffix    (code_suffix),
		.code_has_point (code_has_point),
		.auto_op_cmd    (auto_op_cmd),
		.bus_clear      (bus_clear),
		.ctrl_clear     (ctrl_clear),
		.serial_poll    (serial_poll)
	);
	initial begin
		forever #2.5 clk = ~clk;
	end
	// ====================
	// Tasks
	function automatic logic [31:0] nxt(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic pulse(input logic [4:0] v);
		@(posedge clk);
		pv <= v;
		@(posedge clk);
		pv <= 5'h0;
		#1;
	endtask
	task automatic stop_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		#100000;
		miscompares++;
		stop_test();
	end
	// ====================
	// Tests
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		#1;
		chk({status_byte, func_mode, disp_state, full_resolution}, 16'h0023);
		i_ctrl.send(7'h05, 7'h00, 1'b0);
		chk({srq_line, status_byte}, 9'h142);
		i_ctrl.cmd(4'h1);
		i_ctrl.send(7'h64, 7'h00, 1'b1);
		chk({srq_line, status_byte}, 9'h142);
		i_ctrl.cmd(4'h1);
		$display("code error test done");
		for (int m = 0; m < 8; m++) begin
			i_ctrl.send(7'h16, 7'(m), 1'b1);
			chk({disp_state, disp_code}, {SRF_DISP_FLASH, 7'h16, 7'(m)});
			repeat (101) @(posedge clk);
			#1;
			chk(disp_state, SRF_DISP_MEAS);
			lfsr = nxt(lfsr);
			mask = m | 2;
			exp_sb = {5'h0, lfsr[1] & mask[2], 1'b0, lfsr[0] & mask[0]};
			exp_sb[6] = |exp_sb;
			pulse({3'h0, lfsr[1:0]});
			chk({srq_line, status_byte}, {exp_sb[6], exp_sb});
			i_ctrl.cmd(4'h8);
			chk(status_byte, exp_sb);
			pulse(5'h10);
			chk(disp_srq_pending, exp_sb[6]);
			i_ctrl.cmd(4'(1 << (m % 3)));
			chk({srq_line, status_byte}, 9'h000);
			pulse(5'h02);
			chk(status_byte, (m % 3 == 0 && mask[2]) ? 8'h44 : 8'h00);
			i_ctrl.cmd(4'h1);
		end
		$display("enable mask test done");
		for (int i = 0; i < 5; i++) begin
			lfsr = nxt(lfsr);
			svc = pfx[i] == 7'h00 || pfx[i] > 7'h27;
			if (pfx[i] == 7'h01) s1 = {3'h0, lfsr[3:0]};
			i_ctrl.send(pfx[i], {3'h0, lfsr[3:0]}, 1'b1);
			chk({func_mode, safeguards_off, errors_suppressed},
				{svc ? SRF_MODE_SERVICE : SRF_MODE_USER, svc, pfx[i] == 7'h00});
			i_ctrl.cmd(4'h8);
			chk({func_mode, safeguards_off}, {SRF_MODE_AUTO, 1'b0});
		end
		$display("mode test done");
		@(posedge clk);
		actual_setting <= lfsr[13:7];
		pulse(5'h04);
		chk({disp_state, disp_setting}, {SRF_DISP_REQ, s1});
		pulse(5'h04);
		chk({disp_state, disp_setting}, {SRF_DISP_ACTUAL, lfsr[13:7]});
		pulse(5'h08);
		chk(disp_state, SRF_DISP_MEAS);
		i_ctrl.send(7'h10, 7'h00, 1'b1);
		chk(full_resolution, 1'b0);
		i_ctrl.send(7'h10, 7'h01, 1'b1);
		chk(full_resolution, 1'b1);
		$display("display test done");
		stop_test();
	end
endmodule
